// >>> inc/clt_pkg.sv
package clt_pkg;

   // ***********************
   // register map
   // ***********************
   localparam int CLT_AW = 12;
   localparam int CLT_THREADS = 2;
   localparam logic [11:0] CLT_OFS_CS = 12'h100;
   localparam logic [11:0] CLT_OFS_EA = 12'h108;
   localparam logic [11:0] CLT_OFS_CA = 12'h110;
   localparam logic [11:0] CLT_OFS_RA = 12'h118;
   localparam logic [11:0] CLT_THREAD_STRIDE = 12'h004;

   // ***********************
   // control/status fields
   // ***********************
   localparam int CLT_CS_RESET = 15;
   localparam int CLT_CS_SEMA_HI = 14;
   localparam int CLT_CS_SEMA_LO = 12;
   localparam int CLT_CS_DEPTH_HI = 9;
   localparam int CLT_CS_DEPTH_LO = 8;
   localparam int CLT_CS_RUN = 5;
   localparam int CLT_CS_SUB = 4;
   localparam int CLT_CS_ERR = 3;
   localparam int CLT_CS_PREFIX = 0;
   localparam logic [31:0] CLT_RST_WORD = 32'h00000000;
   localparam logic [2:0] CLT_SEMA_MAX = 3'h7;
   localparam logic [1:0] CLT_STACK_DEPTH = 2'h1;

   // ***********************
   // records
   // ***********************
   localparam logic [31:0] CLT_REC_STEP = 32'h00000004;
   localparam logic [7:0] CLT_OP_NOP = 8'h00;
   localparam logic [7:0] CLT_OP_HALT = 8'h01;
   localparam logic [7:0] CLT_OP_SEM_INC = 8'h02;
   localparam logic [7:0] CLT_OP_SEM_WAIT = 8'h03;
   localparam logic [7:0] CLT_OP_CALL = 8'h04;
   localparam logic [7:0] CLT_OP_RETURN = 8'h05;
   localparam logic [7:0] CLT_OP_TILES = 8'h06;

   typedef enum logic [1:0] {CLT_T_IDLE, CLT_T_FETCH, CLT_T_SEMWAIT} clt_tstate_t;
   typedef enum logic [1:0] {CLT_F_IDLE, CLT_F_REQ, CLT_F_WAIT} clt_fstate_t;

endpackage : clt_pkg

// >>> inc/clt_if.sv
`timescale 1ns/10ps

// register access from the bus slave to the thread core
interface clt_reg_if;
   logic wr;
   logic [11:0] waddr;
   logic [11:0] raddr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport apb (output wr, output waddr, output raddr, output wdata, input rdata);
   modport core (input wr, input waddr, input raddr, input wdata, output rdata);
endinterface : clt_reg_if

// record fetch requests from the threads to the memory port
interface clt_fetch_if;
   logic [1:0] req;
   logic [1:0][31:0] addr;
   logic [1:0] gnt;
   logic [1:0] rvalid;
   logic [31:0] rdata;
   logic rerr;
   modport core (output req, output addr, input gnt, input rvalid, input rdata, input rerr);
   modport mem (input req, input addr, output gnt, output rvalid, output rdata, output rerr);
endinterface : clt_fetch_if

// >>> rtl/clt_apb.sv
`timescale 1ns/10ps

module clt_apb
   import clt_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [CLT_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // register side
   clt_reg_if.apb rif
);

   typedef struct packed {
      logic [31:0] rdata;
      logic err;
   } clt_apb_t;

   clt_apb_t s;
   clt_apb_t next_s;

   // ***********************
   // decode
   // ***********************
   function automatic logic clt_mapped(input logic [11:0] a);
      return (a >= CLT_OFS_CS) && (a <= CLT_OFS_RA + CLT_THREAD_STRIDE) && (a[1:0] == 2'h0);
   endfunction : clt_mapped

   // read data is captured in the setup cycle so the access phase never waits
   always_comb begin
      next_s = s;
      if (psel && !penable) begin
         next_s.err = !clt_mapped(paddr);
         next_s.rdata = clt_mapped(paddr) && !pwrite ? rif.rdata : 32'h00000000;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rif.raddr = paddr;
   assign rif.waddr = paddr;
   assign rif.wdata = pwdata;
   assign rif.wr = psel && penable && pwrite && clt_mapped(paddr);
   assign pready = psel && penable;
   assign pslverr = psel && penable && s.err;
   assign prdata = s.rdata;

endmodule : clt_apb

// >>> rtl/clt_fetch.sv
`timescale 1ns/10ps

module clt_fetch
   import clt_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // thread side
   clt_fetch_if.mem fif,
   // memory port
   output logic mem_req,
   output logic [31:0] mem_addr,
   input wire logic mem_ack,
   input wire logic mem_rvalid,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_rerr
);

   typedef struct packed {
      clt_fstate_t st;
      logic own;
      logic last;
      logic [31:0] addr;
      logic [1:0] rvalid;
      logic [31:0] rdata;
      logic rerr;
   } clt_fetch_t;

   clt_fetch_t s;
   clt_fetch_t next_s;
   logic pick;

   // round robin so a busy thread cannot starve the other
   always_comb begin
      next_s = s;
      next_s.rvalid = 2'h0;
      pick = fif.req[!s.last] ? !s.last : s.last;
      fif.gnt = 2'h0;
      case (s.st)
         CLT_F_IDLE: begin
            if (|fif.req) begin
               fif.gnt[pick] = 1'b1;
               next_s.own = pick;
               next_s.last = pick;
               next_s.addr = fif.addr[pick];
               next_s.st = CLT_F_REQ;
            end
         end
         CLT_F_REQ: begin
            if (mem_ack) begin
               next_s.st = CLT_F_WAIT;
            end
         end
         CLT_F_WAIT: begin
            if (mem_rvalid) begin
               next_s.rvalid[s.own] = 1'b1;
               next_s.rdata = mem_rdata;
               next_s.rerr = mem_rerr;
               next_s.st = CLT_F_IDLE;
            end
         end
         default: begin
            next_s.st = CLT_F_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign mem_req = (s.st == CLT_F_REQ);
   assign mem_addr = s.addr;
   assign fif.rvalid = s.rvalid;
   assign fif.rdata = s.rdata;
   assign fif.rerr = s.rerr;

endmodule : clt_fetch

// >>> rtl/clt_top.sv
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps

// Function
// - two threads, binning and rendering, own registers
// - reset bit stops thread, clears register
// - semaphore value readable, read-only, resets zero
// - nesting depth readable, read-only, resets zero
// - run flag shows running; writing one halts
// - stopped sub-mode: end zero, halt one
// - running sub-mode: one while stalled waiting
// - writing sub-mode clears halt, restarts if needed
// - error flag set on error stop, cleared restart
// - binning prefix flag one until tiles start
// - end write restarts thread stopped at end or on error
// - current address tracks record being processed
// - current address writable only while stopped
// - current address write sets stopped-at-end
// - one-deep return stack, readable, resets zero
module clt_top
   import clt_pkg::*;
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RESET,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [CLT_AW-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // record memory port
   output logic MEM_REQ,
   output logic [31:0] MEM_ADDR,
   input wire logic MEM_ACK,
   input wire logic MEM_RVALID,
   input wire logic [31:0] MEM_RDATA,
   input wire logic MEM_RERR,
   // thread status
   output logic [CLT_THREADS-1:0] THREAD_RUN
);

   // ***********************
   // state
   // ***********************
   typedef struct packed {
      clt_tstate_t st;
      logic run;
      logic sub;
      logic err;
      logic tiles;
      logic [2:0] sema;
      logic [1:0] depth;
      logic [31:0] cur;
      logic [31:0] lend;
      logic [31:0] ret;
      logic pend;
      logic stale;
   } clt_thr_t;

   typedef struct packed {
      clt_thr_t [CLT_THREADS-1:0] thr;
   } clt_state_t;

   clt_state_t s;
   clt_state_t next_s;
   logic [CLT_THREADS-1:0] sem_inc;
   logic [CLT_THREADS-1:0] sem_dec;

   clt_reg_if rif ();
   clt_fetch_if fif ();

   // ***********************
   // helpers
   // ***********************
   function automatic logic clt_hit(input logic [11:0] a, input logic [11:0] base,
                                    input int i);
      return a == base + (i != 0 ? CLT_THREAD_STRIDE : 12'h000);
   endfunction : clt_hit

   function automatic logic [31:0] clt_cs_word(input clt_thr_t t, input logic binning);
      logic [31:0] w;
      w = CLT_RST_WORD;
      w[CLT_CS_SEMA_HI:CLT_CS_SEMA_LO] = t.sema;
      w[CLT_CS_DEPTH_HI:CLT_CS_DEPTH_LO] = t.depth;
      w[CLT_CS_RUN] = t.run;
      w[CLT_CS_SUB] = t.sub;
      w[CLT_CS_ERR] = t.err;
      w[CLT_CS_PREFIX] = binning && !t.tiles;
      return w;
   endfunction : clt_cs_word

   // stop a thread; a read still in flight is dropped when it returns
   function automatic clt_thr_t clt_stop(input clt_thr_t t, input logic halt);
      clt_thr_t r;
      r = t;
      r.run = 1'b0;
      r.sub = halt;
      r.st = CLT_T_IDLE;
      r.stale = t.pend;
      return r;
   endfunction : clt_stop

   function automatic clt_thr_t clt_start(input clt_thr_t t);
      clt_thr_t r;
      r = t;
      r.run = 1'b1;
      r.sub = 1'b0;
      r.err = 1'b0;
      r.st = CLT_T_FETCH;
      return r;
   endfunction : clt_start

   // ***********************
   // thread engine
   // ***********************
   always_comb begin
      next_s = s;
      sem_inc = '0;
      sem_dec = '0;
      fif.req = '0;
      for (int i = 0; i < CLT_THREADS; i++) begin
         fif.addr[i] = s.thr[i].cur;
         if (fif.gnt[i]) begin
            next_s.thr[i].pend = 1'b1;
         end
         if (fif.rvalid[i]) begin
            next_s.thr[i].pend = 1'b0;
            next_s.thr[i].stale = 1'b0;
         end
         case (s.thr[i].st)
            CLT_T_IDLE: begin
            end
            CLT_T_FETCH: begin
               if (fif.rvalid[i] && !s.thr[i].stale) begin
                  // cur names the record until it has been acted on
                  next_s.thr[i].cur = s.thr[i].cur + CLT_REC_STEP;
                  if (fif.rerr) begin
                     next_s.thr[i] = clt_stop(next_s.thr[i], 1'b0);
                     next_s.thr[i].err = 1'b1;
                  end else begin
                     case (fif.rdata[7:0])
                        CLT_OP_NOP: begin
                        end
                        CLT_OP_HALT: begin
                           next_s.thr[i] = clt_stop(next_s.thr[i], 1'b1);
                        end
                        CLT_OP_SEM_INC: begin
                           sem_inc[CLT_THREADS-1-i] = 1'b1;
                        end
                        CLT_OP_SEM_WAIT: begin
                           next_s.thr[i].cur = s.thr[i].cur;
                           next_s.thr[i].st = CLT_T_SEMWAIT;
                           next_s.thr[i].sub = 1'b1;
                        end
                        CLT_OP_CALL: begin
                           if (s.thr[i].depth == CLT_STACK_DEPTH) begin
                              next_s.thr[i] = clt_stop(next_s.thr[i], 1'b0);
                              next_s.thr[i].err = 1'b1;
                           end else begin
                              next_s.thr[i].ret = s.thr[i].cur + CLT_REC_STEP;
                              next_s.thr[i].depth = s.thr[i].depth + 2'h1;
                              next_s.thr[i].cur = {fif.rdata[31:8], 8'h00};
                           end
                        end
                        CLT_OP_RETURN: begin
                           if (s.thr[i].depth == 2'h0) begin
                              next_s.thr[i] = clt_stop(next_s.thr[i], 1'b0);
                              next_s.thr[i].err = 1'b1;
                           end else begin
                              next_s.thr[i].cur = s.thr[i].ret;
                              next_s.thr[i].depth = s.thr[i].depth - 2'h1;
                           end
                        end
                        CLT_OP_TILES: begin
                           next_s.thr[i].tiles = 1'b1;
                        end
                        default: begin
                           next_s.thr[i] = clt_stop(next_s.thr[i], 1'b0);
                           next_s.thr[i].err = 1'b1;
                        end
                     endcase
                  end
               end else if (!s.thr[i].pend && !s.thr[i].stale) begin
                  if (s.thr[i].cur == s.thr[i].lend) begin
                     next_s.thr[i] = clt_stop(next_s.thr[i], 1'b0);
                  end else begin
                     fif.req[i] = 1'b1;
                  end
               end
            end
            CLT_T_SEMWAIT: begin
               // stalled until the other thread signals
               if (s.thr[i].sema != 3'h0) begin
                  sem_dec[i] = 1'b1;
                  next_s.thr[i].cur = s.thr[i].cur + CLT_REC_STEP;
                  next_s.thr[i].sub = 1'b0;
                  next_s.thr[i].st = CLT_T_FETCH;
               end
            end
            default: begin
               next_s.thr[i].st = CLT_T_IDLE;
            end
         endcase
      end

      // semaphores saturate rather than wrap, so a runaway producer is visible
      for (int i = 0; i < CLT_THREADS; i++) begin
         if (sem_inc[i] && !sem_dec[i] && s.thr[i].sema != CLT_SEMA_MAX) begin
            next_s.thr[i].sema = s.thr[i].sema + 3'h1;
         end else if (sem_dec[i] && !sem_inc[i]) begin
            next_s.thr[i].sema = s.thr[i].sema - 3'h1;
         end
      end

      // ***********************
      // register writes
      // ***********************
      // software writes land after the engine so they win in a shared cycle
      for (int i = 0; i < CLT_THREADS; i++) begin
         if (rif.wr && clt_hit(rif.waddr, CLT_OFS_CS, i)) begin
            if (rif.wdata[CLT_CS_RESET]) begin
               next_s.thr[i] = clt_stop(next_s.thr[i], 1'b0);
               next_s.thr[i].err = 1'b0;
               next_s.thr[i].sema = 3'h0;
               next_s.thr[i].depth = 2'h0;
               next_s.thr[i].tiles = 1'b0;
            end else if (rif.wdata[CLT_CS_RUN]) begin
               next_s.thr[i] = clt_stop(next_s.thr[i], 1'b1);
            end else if (rif.wdata[CLT_CS_SUB] && !s.thr[i].run) begin
               next_s.thr[i].sub = 1'b0;
               if (s.thr[i].cur != s.thr[i].lend) begin
                  next_s.thr[i] = clt_start(next_s.thr[i]);
               end
            end
         end
         if (rif.wr && clt_hit(rif.waddr, CLT_OFS_EA, i)) begin
            next_s.thr[i].lend = rif.wdata;
            if (!s.thr[i].run && !s.thr[i].sub && s.thr[i].cur != rif.wdata) begin
               next_s.thr[i] = clt_start(next_s.thr[i]);
            end
         end
         if (rif.wr && clt_hit(rif.waddr, CLT_OFS_CA, i) && !s.thr[i].run) begin
            next_s.thr[i].cur = rif.wdata;
            next_s.thr[i].sub = 1'b0;
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ***********************
   // register read
   // ***********************
   always_comb begin
      rif.rdata = 32'h00000000;
      for (int i = 0; i < CLT_THREADS; i++) begin
         if (clt_hit(rif.raddr, CLT_OFS_CS, i)) begin
            rif.rdata = clt_cs_word(s.thr[i], i == 0);
         end
         if (clt_hit(rif.raddr, CLT_OFS_EA, i)) begin
            rif.rdata = s.thr[i].lend;
         end
         if (clt_hit(rif.raddr, CLT_OFS_CA, i)) begin
            rif.rdata = s.thr[i].cur;
         end
         if (clt_hit(rif.raddr, CLT_OFS_RA, i)) begin
            rif.rdata = s.thr[i].ret;
         end
      end
   end

   always_comb begin
      for (int i = 0; i < CLT_THREADS; i++) begin
         THREAD_RUN[i] = s.thr[i].run;
      end
   end

   // ***********************
   // submodules
   // ***********************
   clt_apb u_apb (
      .clock(CLOCK),
      .reset(RESET),
      .psel(PSEL),
      .penable(PENABLE),
      .pwrite(PWRITE),
      .paddr(PADDR),
      .pwdata(PWDATA),
      .prdata(PRDATA),
      .pready(PREADY),
      .pslverr(PSLVERR),
      .rif(rif.apb)
   );

   // memory shares CLOCK, so its handshake needs no synchroniser
   clt_fetch u_fetch (
      .clock(CLOCK),
      .reset(RESET),
      .fif(fif.mem),
      .mem_req(MEM_REQ),
      .mem_addr(MEM_ADDR),
      .mem_ack(MEM_ACK),
      .mem_rvalid(MEM_RVALID),
      .mem_rdata(MEM_RDATA),
      .mem_rerr(MEM_RERR)
   );

endmodule : clt_top

// >>> test/clt_chk_sva.sv
`timescale 1ns/10ps
// ****************
// port checker
// ****************
module clt_chk
   import clt_pkg::*;
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RESET,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // record memory port
   input wire logic MEM_REQ,
   input wire logic [31:0] MEM_ADDR,
   input wire logic MEM_ACK,
   input wire logic MEM_RVALID,
   // thread status
   input wire logic [CLT_THREADS-1:0] THREAD_RUN
);
   // one read in flight at most
   logic busy;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RESET);
   always_ff @(posedge CLOCK) begin
      if (RESET) busy <= 1'b0;
      else if (MEM_REQ && MEM_ACK) busy <= 1'b1;
      else if (MEM_RVALID) busy <= 1'b0;
   end
   chk_ready_access: assert property (PREADY == (PSEL && PENABLE))
      else $error("ready not tied to access phase");
   chk_err_access: assert property (PSLVERR |-> PSEL && PENABLE)
      else $error("slave error outside access phase");
   // read data is loaded at the setup edge, so it may only be held from the access onwards
   chk_rdata_held: assert property (PSEL && PENABLE |=> $stable(PRDATA))
      else $error("read data moved right after access phase");
   chk_req_holds: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
      else $error("request dropped before ack");
   chk_req_drops: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ)
      else $error("request kept after ack");
   chk_req_gap: assert property (MEM_RVALID |=> !MEM_REQ)
      else $error("request right after read data");
   chk_addr_word: assert property (MEM_REQ |-> MEM_ADDR[1:0] == 2'h0)
      else $error("record address not word aligned");
   chk_one_read: assert property (MEM_REQ |-> !busy)
      else $error("second read while one outstanding");
   chk_start_fetch: assert property ($rose(|THREAD_RUN) |-> ##[1:40] MEM_REQ)
      else $error("started thread never fetched");
endmodule : clt_chk

// >>> test/clt_mem_model.sv
`timescale 1ns/10ps
// ****************
// record memory
// ****************
module clt_mem_model (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // request side
   input wire logic req,
   input wire logic [31:0] addr,
   output logic ack,
   output logic rvalid,
   output logic [31:0] rdata,
   output logic rerr,
   // pacing
   input wire logic slow
);
   logic [31:0] mem [0:127];
   logic [127:0] bad;
   logic [3:0] cnt;
   logic pend;
   logic [6:0] idx;
   always_ff @(posedge clock) begin
      if (reset) begin
         ack <= 1'b0;
         rvalid <= 1'b0;
         rerr <= 1'b0;
         pend <= 1'b0;
         cnt <= 4'h0;
         rdata <= 32'hA5A5A5A5;
      end else begin
         // data lines toggle outside a reply so stale data never looks valid
         rdata <= ~rdata;
         rvalid <= 1'b0;
         rerr <= 1'b0;
         ack <= req && !ack && !pend;
         if (req && ack) begin
            pend <= 1'b1;
            idx <= addr[8:2];
            cnt <= slow ? 4'h6 : 4'h0;
         end else if (pend && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end else if (pend) begin
            pend <= 1'b0;
            rvalid <= 1'b1;
            rdata <= mem[idx];
            rerr <= bad[idx];
         end
      end
   end
endmodule : clt_mem_model

// >>> test/test_control_list_thread_ctrl.sv
`timescale 1ns/10ps
module test_control_list_thread_ctrl;
   import clt_pkg::*;
   logic CLOCK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, slow, er;
   logic MEM_REQ, MEM_ACK, MEM_RVALID, MEM_RERR;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, MEM_ADDR, MEM_RDATA, rd;
   logic [1:0] THREAD_RUN;
   int fails, num_checks, cyc;
   clt_top u_clt_top (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK),
      .MEM_RVALID(MEM_RVALID), .MEM_RDATA(MEM_RDATA), .MEM_RERR(MEM_RERR),
      .THREAD_RUN(THREAD_RUN));
   clt_mem_model u_clt_mem_model (.clock(CLOCK), .reset(RESET), .req(MEM_REQ),
      .addr(MEM_ADDR), .ack(MEM_ACK), .rvalid(MEM_RVALID), .rdata(MEM_RDATA),
      .rerr(MEM_RERR), .slow(slow));
   // ****************
   // clock, timeout
   // ****************
   initial begin
      CLOCK = 1'b0;
      forever #5 CLOCK = ~CLOCK;
   end
   initial cyc = 0;
   always @(posedge CLOCK) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end
   // ****************
   // tasks
   // ****************
   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      @(posedge CLOCK);
      while (PREADY !== 1'b1) @(posedge CLOCK);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : xfer
   task rchk(input string n, input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask : rchk
   task wait_stop(input int t);
      repeat (3) @(posedge CLOCK);
      for (int k = 0; k < 200 && THREAD_RUN[t] !== 1'b0; k++) @(posedge CLOCK);
      chk("run pin", 32'h0, 32'(THREAD_RUN[t]));
   endtask : wait_stop
   // ****************
   // tests
   // ****************
   initial begin
      RESET = 1'b1;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 12'h000;
      PWDATA = 32'h0;
      slow = 1'b0;
      fails = 0;
      num_checks = 0;
      repeat (20) @(posedge CLOCK);
      for (int i = 0; i < 128; i++) begin
         u_clt_mem_model.mem[i] = 32'h0;
         u_clt_mem_model.bad[i] = 1'b0;
      end
      u_clt_mem_model.mem[1] = 32'h06;
      u_clt_mem_model.mem[4] = 32'h01;
      u_clt_mem_model.mem[8] = 32'h104;
      u_clt_mem_model.mem[64] = 32'h01;
      u_clt_mem_model.mem[65] = 32'h05;
      u_clt_mem_model.mem[12] = 32'hFF;
      u_clt_mem_model.bad[14] = 1'b1;
      u_clt_mem_model.mem[24] = 32'h02;
      u_clt_mem_model.mem[25] = 32'h02;
      for (int i = 32; i < 35; i++) u_clt_mem_model.mem[i] = 32'h03;
      RESET <= 1'b0;
      rchk("cs0", 12'h100, 32'h1);
      rchk("cs1", 12'h104, 32'h0);
      rchk("ra1", 12'h11C, 32'h0);
      xfer(1'b0, 12'h200, 32'h0);
      chk("unmapped err", 32'h1, 32'(er));
      $display("test reset done");
      xfer(1'b1, 12'h108, 32'hC);
      wait_stop(0);
      rchk("ca0", 12'h110, 32'hC);
      rchk("cs0", 12'h100, 32'h0);
      $display("test sequential done");
      xfer(1'b1, 12'h114, 32'h10);
      xfer(1'b1, 12'h10C, 32'h18);
      wait_stop(1);
      rchk("cs1", 12'h104, 32'h10);
      rchk("ca1", 12'h114, 32'h14);
      xfer(1'b1, 12'h10C, 32'h18);
      repeat (5) @(posedge CLOCK);
      rchk("cs1", 12'h104, 32'h10);
      xfer(1'b1, 12'h104, 32'h10);
      wait_stop(1);
      rchk("ca1", 12'h114, 32'h18);
      $display("test halt done");
      slow <= 1'b1;
      xfer(1'b1, 12'h110, 32'h20);
      xfer(1'b1, 12'h108, 32'h28);
      wait_stop(0);
      rchk("cs0", 12'h100, 32'h110);
      rchk("ca0", 12'h110, 32'h104);
      xfer(1'b1, 12'h118, 32'hFFFFFFFF);
      rchk("ra0", 12'h118, 32'h24);
      xfer(1'b1, 12'h110, 32'h104);
      rchk("cs0", 12'h100, 32'h100);
      xfer(1'b1, 12'h108, 32'h28);
      wait_stop(0);
      rchk("ca0", 12'h110, 32'h28);
      rchk("cs0", 12'h100, 32'h0);
      $display("test nesting done");
      slow <= 1'b0;
      xfer(1'b1, 12'h114, 32'h30);
      xfer(1'b1, 12'h10C, 32'h34);
      wait_stop(1);
      rchk("cs1", 12'h104, 32'h8);
      xfer(1'b1, 12'h10C, 32'h3C);
      wait_stop(1);
      rchk("ca1", 12'h114, 32'h3C);
      rchk("cs1", 12'h104, 32'h8);
      xfer(1'b1, 12'h10C, 32'h40);
      wait_stop(1);
      rchk("cs1", 12'h104, 32'h0);
      $display("test error done");
      xfer(1'b1, 12'h110, 32'h60);
      xfer(1'b1, 12'h108, 32'h68);
      wait_stop(0);
      rchk("sema1", 12'h104, 32'h2000);
      xfer(1'b1, 12'h114, 32'h80);
      xfer(1'b1, 12'h10C, 32'h8C);
      for (int k = 0; k < 40; k++) begin
         xfer(1'b0, 12'h104, 32'h0);
         if (rd === 32'h30) break;
      end
      chk("stall", 32'h30, rd);
      xfer(1'b1, 12'h104, 32'h20);
      wait_stop(1);
      rchk("cs1", 12'h104, 32'h10);
      xfer(1'b1, 12'h104, 32'h8000);
      rchk("cs1", 12'h104, 32'h0);
      $display("test semaphore done");
      report_and_stop();
   end
endmodule : test_control_list_thread_ctrl
bind clt_top clt_chk u_clt_chk (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_REQ(MEM_REQ),
   .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK), .MEM_RVALID(MEM_RVALID),
   .THREAD_RUN(THREAD_RUN));
